// >>> logic/clock_source_pkg.sv
// Purpose: constants for the clock source and ratio configuration block
// Assumes: 8-bit register file reached through a simple byte-wide port
// Notes: offsets and reset values shared by design and bench
package clock_source_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] clock_source_config_addr = 8'h34;
  localparam logic [7:0] ratio_high_addr = 8'h35;
  localparam logic [7:0] ratio_low_addr = 8'h36;
  // ==========================================================
  // reset values
  localparam logic [7:0] clock_source_config_rst = 8'h40;
  localparam logic [7:0] ratio_high_rst = 8'h00;
  localparam logic [7:0] ratio_low_rst = 8'h00;
  // ==========================================================
  // field positions in clock_source_config
  localparam int loop_off_bit = 7;
  localparam int fractional_loop_allow_bit = 6;
  localparam int reserved_hi_bit = 5;
  localparam int reserved_lo_bit = 4;
  localparam int source_lsb = 1;
  localparam int ratio_edge_bit = 0;
  // field position in the rate and ratio high register, ratio width and checker counter width
  localparam int rate_lsb = 6;
  localparam int ratio_width = 14;
  localparam int count_width = 16;
  // ==========================================================
  // input source codes
  typedef enum logic [2:0] {
    src_primary_bit_clock = 3'b000,
    src_ref_primary_frame = 3'b001,
    src_secondary_bit_clock = 3'b010,
    src_ref_secondary_frame = 3'b011,
    src_fixed_ref = 3'b100,
    src_internal_osc = 3'b101,
    src_reserved_6 = 3'b110,
    src_reserved_7 = 3'b111
  } input_source_e;
  // density-modulated clock rate codes
  typedef enum logic [1:0] {
    rate_3m = 2'b00,
    rate_1m5 = 2'b01,
    rate_768k = 2'b10,
    rate_6m = 2'b11
  } density_rate_e;
  // ratio checker states
  typedef enum logic [1:0] {
    chk_idle = 2'b00,
    chk_count = 2'b01
  } checker_state_e;
endpackage

// >>> logic/ratio_checker.sv
// Purpose: counts clock-source edges between frame-sync starts
// Assumes: source and frame inputs synchronous to i_clk
// Notes: zero programmed ratio means adopt the measured count
`timescale 1ns/1ps
module ratio_checker #(
  parameter int count_width = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_source_clock,
  input wire logic i_frame_sync,
  input wire logic i_use_falling,
  input wire logic [13:0] i_ratio,
  output logic [13:0] o_ratio_detected,
  output logic o_ratio_locked,
  output logic o_ratio_error
);
  // ==========================================================
  // edge detection
  logic src_d;
  logic frame_d;
  logic edge_hit;
  logic frame_start;
  logic [count_width-1:0] count;
  logic [count_width-1:0] next_count;
  logic [13:0] next_detected;
  logic next_locked;
  logic next_error;
  clock_source_pkg::checker_state_e state;
  clock_source_pkg::checker_state_e next_state;

  // selected edge of the clock source
  assign edge_hit = i_use_falling ? (src_d & ~i_source_clock) : (~src_d & i_source_clock);
  assign frame_start = i_frame_sync & ~frame_d;

  // ==========================================================
  // next-state logic
  always_comb begin
    next_state = state;
    next_count = count;
    next_detected = o_ratio_detected;
    next_locked = o_ratio_locked;
    next_error = o_ratio_error;
    case (state)
      clock_source_pkg::chk_idle: begin
        if (frame_start) begin
          next_state = clock_source_pkg::chk_count;
          next_count = '0;
        end
      end
      clock_source_pkg::chk_count: begin
        if (frame_start) begin
          next_count = '0;
          if (i_ratio == 14'h0000) begin
            next_detected = count[13:0];
            next_locked = 1'b1;
            next_error = 1'b0;
          end else begin
            next_detected = i_ratio;
            next_locked = (count[13:0] == i_ratio);
            next_error = (count[13:0] != i_ratio);
          end
        end else if (edge_hit && count != {count_width{1'b1}}) begin
          next_count = count + 1'b1;
        end
      end
      default: next_state = clock_source_pkg::chk_idle;
    endcase
  end

  // registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= clock_source_pkg::chk_idle;
      count <= '0;
      src_d <= 1'b0;
      frame_d <= 1'b0;
      o_ratio_detected <= 14'h0000;
      o_ratio_locked <= 1'b0;
      o_ratio_error <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      src_d <= i_source_clock;
      frame_d <= i_frame_sync;
      o_ratio_detected <= next_detected;
      o_ratio_locked <= next_locked;
      o_ratio_error <= next_error;
    end
  end

  // ==========================================================
  // checks
  a_ratio_mismatch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == clock_source_pkg::chk_count && frame_start && i_ratio != 14'h0000
     && count[13:0] != i_ratio) |=> o_ratio_error && !o_ratio_locked)
    else $error("ratio mismatch not flagged");
  a_auto_adopt: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == clock_source_pkg::chk_count && frame_start && i_ratio == 14'h0000)
    |=> o_ratio_detected == $past(count[13:0]) && o_ratio_locked)
    else $error("auto ratio not adopted");
  c_auto_lock: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    i_ratio == 14'h0000 && o_ratio_locked);
  c_mismatch: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_ratio_error);
endmodule // ratio_checker

// >>> logic/clock_source_config.sv
// Purpose: clock source, loop and ratio configuration registers
// Assumes: byte-wide register port synchronous to i_clk
// Notes: reads are combinational from registered state
//
// Overview of operation
// - Loop runs always in custom mode and on demand in auto mode while loop_off is clear; set turns it off.
// - fractional_loop_allow permits fractional loop operation when set and resets set.
// - Source codes 0 to 3 pick primary bit clock, ref locked to primary frame, secondary bit clock, ref locked to secondary frame.
// - Code 4 is fixed ref only in controller mode, code 5 oscillator only in custom mode, 6 and 7 reserved.
// - ratio_edge picks the rising edge when clear and the falling edge when set for ratio checking.
// - The two-bit density_mod_clock_rate selects 3M, 1.5M, 768k or 6M class output clock.
// - The ratio is 14 bits, six high bits and eight low bits, nonzero values set it explicitly.
// - A zero ratio makes the device detect the ratio automatically.
// - Reserved bits 5 and 4 of the source register read zero and take only zero.
// - Source register at 0x34 resets to 0x40, the next two reset to zero.
`timescale 1ns/1ps
module clock_source_config #(
  parameter int count_width = clock_source_pkg::count_width
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_reg_write,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_custom_mode,
  input wire logic i_controller_mode,
  input wire logic i_dsp_load_high,
  input wire logic i_primary_bit_clock,
  input wire logic i_secondary_bit_clock,
  input wire logic i_controller_ref_clock,
  input wire logic i_internal_osc,
  input wire logic i_primary_frame_sync,
  input wire logic i_secondary_frame_sync,
  output logic o_loop_enable,
  output logic o_fractional_allow,
  output logic o_source_clock,
  output logic o_source_invalid,
  output logic [1:0] o_density_mod_clock_rate,
  output logic o_ratio_auto,
  output logic [13:0] o_ref_frame_ratio,
  output logic o_ratio_locked,
  output logic o_ratio_error
);
  // ==========================================================
  // register state
  logic [7:0] clock_source_config;
  logic [7:0] ctrl_clock_config_rate_ratio_high;
  logic [7:0] ctrl_clock_config_ratio_low;
  logic [7:0] next_clock_source_config;
  logic [7:0] next_rate_ratio_high;
  logic [7:0] next_ratio_low;
  logic [2:0] input_source_select;
  logic [13:0] ratio_prog;
  logic frame_sel;
  logic [13:0] ratio_detected;

  // register writes
  always_comb begin
    next_clock_source_config = clock_source_config;
    next_rate_ratio_high = ctrl_clock_config_rate_ratio_high;
    next_ratio_low = ctrl_clock_config_ratio_low;
    if (i_reg_write) begin
      case (i_reg_addr)
        clock_source_pkg::clock_source_config_addr: begin
          next_clock_source_config = i_reg_wdata;
          next_clock_source_config[clock_source_pkg::reserved_hi_bit] = 1'b0;
          next_clock_source_config[clock_source_pkg::reserved_lo_bit] = 1'b0;
        end
        clock_source_pkg::ratio_high_addr: next_rate_ratio_high = i_reg_wdata;
        clock_source_pkg::ratio_low_addr: next_ratio_low = i_reg_wdata;
        default: ;
      endcase
    end
  end

  // register update with documented reset values
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      clock_source_config <= clock_source_pkg::clock_source_config_rst;
      ctrl_clock_config_rate_ratio_high <= clock_source_pkg::ratio_high_rst;
      ctrl_clock_config_ratio_low <= clock_source_pkg::ratio_low_rst;
    end else begin
      clock_source_config <= next_clock_source_config;
      ctrl_clock_config_rate_ratio_high <= next_rate_ratio_high;
      ctrl_clock_config_ratio_low <= next_ratio_low;
    end
  end

  // ==========================================================
  // readback, unmapped reads as zero
  always_comb begin
    case (i_reg_addr)
      clock_source_pkg::clock_source_config_addr: o_reg_rdata = clock_source_config;
      clock_source_pkg::ratio_high_addr: o_reg_rdata = ctrl_clock_config_rate_ratio_high;
      clock_source_pkg::ratio_low_addr: o_reg_rdata = ctrl_clock_config_ratio_low;
      default: o_reg_rdata = 8'h00;
    endcase
  end

  // ==========================================================
  // loop control
  assign o_loop_enable = !clock_source_config[clock_source_pkg::loop_off_bit]
                         && (i_custom_mode || i_dsp_load_high);
  assign o_fractional_allow = clock_source_config[clock_source_pkg::fractional_loop_allow_bit];
  assign o_density_mod_clock_rate = ctrl_clock_config_rate_ratio_high[clock_source_pkg::rate_lsb +: 2];

  // ==========================================================
  // source selection
  assign input_source_select = clock_source_config[clock_source_pkg::source_lsb +: 3];
  always_comb begin
    o_source_clock = 1'b0;
    o_source_invalid = 1'b0;
    frame_sel = 1'b0;
    case (clock_source_pkg::input_source_e'(input_source_select))
      clock_source_pkg::src_primary_bit_clock: o_source_clock = i_primary_bit_clock;
      clock_source_pkg::src_ref_primary_frame: o_source_clock = i_controller_ref_clock;
      clock_source_pkg::src_secondary_bit_clock: begin
        o_source_clock = i_secondary_bit_clock;
        frame_sel = 1'b1;
      end
      clock_source_pkg::src_ref_secondary_frame: begin
        o_source_clock = i_controller_ref_clock;
        frame_sel = 1'b1;
      end
      clock_source_pkg::src_fixed_ref: begin
        o_source_clock = i_controller_mode ? i_controller_ref_clock : 1'b0;
        o_source_invalid = !i_controller_mode;
      end
      clock_source_pkg::src_internal_osc: begin
        o_source_clock = i_custom_mode ? i_internal_osc : 1'b0;
        o_source_invalid = !i_custom_mode;
      end
      default: o_source_invalid = 1'b1;
    endcase
  end

  // ==========================================================
  // ratio assembly and detection
  assign ratio_prog = {ctrl_clock_config_rate_ratio_high[5:0], ctrl_clock_config_ratio_low};
  assign o_ratio_auto = (ratio_prog == 14'h0000);
  assign o_ref_frame_ratio = ratio_detected;

  // edge counter between frame starts
  ratio_checker #(
    .count_width(count_width)
  ) i_ratio_checker (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_source_clock(o_source_clock),
    .i_frame_sync(frame_sel ? i_secondary_frame_sync : i_primary_frame_sync),
    .i_use_falling(clock_source_config[clock_source_pkg::ratio_edge_bit]),
    .i_ratio(ratio_prog),
    .o_ratio_detected(ratio_detected),
    .o_ratio_locked(o_ratio_locked),
    .o_ratio_error(o_ratio_error)
  );

  // ==========================================================
  // checks
  a_loop_off_wins: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    clock_source_config[7] |-> !o_loop_enable)
    else $error("loop enabled while off");
  a_custom_loop_on: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!clock_source_config[7] && i_custom_mode) |-> o_loop_enable)
    else $error("loop off in custom mode");
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_reg_write && i_reg_addr == 8'h34) |=> clock_source_config[5:4] == 2'b00)
    else $error("reserved bits nonzero");
  a_reset_values: assert property (@(posedge i_clk)
    i_sys_rst |=> clock_source_config == 8'h40 && ctrl_clock_config_ratio_low == 8'h00)
    else $error("wrong reset value");
  a_write_fraction: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_reg_write && i_reg_addr == 8'h34) |=> o_fractional_allow == $past(i_reg_wdata[6]))
    else $error("fraction bit not stored");
  a_rate_field: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_reg_write && i_reg_addr == 8'h35) |=> o_density_mod_clock_rate == $past(i_reg_wdata[7:6]))
    else $error("rate field not stored");
  a_ratio_auto: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_ratio_auto == (ctrl_clock_config_rate_ratio_high[5:0] == 6'h00 && ctrl_clock_config_ratio_low == 8'h00))
    else $error("auto flag wrong");
  a_source_map: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (input_source_select == 3'h2) |-> o_source_clock == i_secondary_bit_clock)
    else $error("source select wrong");
  a_reserved_code: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (input_source_select[2:1] == 2'b11) |-> o_source_invalid)
    else $error("reserved code not flagged");
  // decode of legal source codes 0, 1, 3, 4 and 5 (code 2 checked above), loop demand, stored fields
  a_source_primary: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (input_source_select == 3'h0) |-> o_source_clock == i_primary_bit_clock && !o_source_invalid)
    else $error("primary bit clock not selected");
  a_source_ref_pri: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (input_source_select == 3'h1) |-> o_source_clock == i_controller_ref_clock && !o_source_invalid)
    else $error("primary locked reference not selected");
  a_source_ref_sec: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (input_source_select == 3'h3) |-> o_source_clock == i_controller_ref_clock && !o_source_invalid)
    else $error("secondary locked reference not selected");
  a_fixed_ref_ok: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (input_source_select == 3'h4 && i_controller_mode) |-> o_source_clock == i_controller_ref_clock && !o_source_invalid)
    else $error("fixed reference not selected");
  a_osc_custom_ok: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (input_source_select == 3'h5 && i_custom_mode) |-> o_source_clock == i_internal_osc && !o_source_invalid)
    else $error("oscillator not selected");
  a_mode_mismatch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ((input_source_select == 3'h4 && !i_controller_mode) || (input_source_select == 3'h5 && !i_custom_mode))
    |-> o_source_invalid && !o_source_clock)
    else $error("source outside its mode not flagged");
  a_auto_loop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!clock_source_config[7] && !i_custom_mode) |-> o_loop_enable == i_dsp_load_high)
    else $error("auto mode loop demand wrong");
  a_reset_high: assert property (@(posedge i_clk)
    i_sys_rst |=> ctrl_clock_config_rate_ratio_high == 8'h00)
    else $error("wrong rate register reset value");
  a_edge_stored: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_reg_write && i_reg_addr == 8'h34) |=> clock_source_config[0] == $past(i_reg_wdata[0]))
    else $error("edge select not stored");
  a_ratio_bytes: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_reg_write && i_reg_addr == 8'h36) |=> ratio_prog[7:0] == $past(i_reg_wdata))
    else $error("low ratio byte not stored");
  c_secondary_src: cover property (@(posedge i_clk) disable iff (i_sys_rst) input_source_select == 3'h3);
  c_loop_off: cover property (@(posedge i_clk) disable iff (i_sys_rst) clock_source_config[7]);
  c_osc_src: cover property (@(posedge i_clk) disable iff (i_sys_rst) input_source_select == 3'h5 && i_custom_mode);
endmodule // clock_source_config

// >>> test/clock_source_config_tb_top.sv
// Purpose: self-checking bench for the clock source and ratio configuration block
// Assumes: byte-wide register port, frame and bit clock lines driven as sampled levels
// Notes: mode and source rows in a table, ratio detection and resets by hand
`timescale 1ns/1ps
module clock_source_config_tb_top;
  // ==========================================================
  // signals
  typedef struct packed {
    logic [7:0] wd;
    logic [2:0] mode;
    logic [3:0] lvl;
    logic [7:0] rd;
    logic [3:0] exp;
  } row_s;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_reg_write = 1'b0;
  logic [7:0] i_reg_addr = 8'h34;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_custom_mode = 1'b0, i_controller_mode = 1'b0, i_dsp_load_high = 1'b0;
  logic i_primary_bit_clock = 1'b0, i_secondary_bit_clock = 1'b0;
  logic i_controller_ref_clock = 1'b0, i_internal_osc = 1'b0;
  logic i_primary_frame_sync = 1'b0, i_secondary_frame_sync = 1'b0;
  logic [7:0] o_reg_rdata;
  logic o_loop_enable, o_fractional_allow, o_source_clock, o_source_invalid;
  logic [1:0] o_density_mod_clock_rate;
  logic o_ratio_auto, o_ratio_locked, o_ratio_error;
  logic [13:0] o_ref_frame_ratio;
  logic [3:0] flags;
  assign flags = {o_loop_enable, o_fractional_allow, o_source_clock, o_source_invalid};
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // rows: mode {custom,controller,load}, levels {pri,sec,ref,osc}, exp {loop,frac,src,invalid}
  row_s rows [12] = '{
    '{8'h40, 3'b100, 4'b1000, 8'h40, 4'b1110}, '{8'h02, 3'b000, 4'b0010, 8'h02, 4'b0010},
    '{8'h04, 3'b001, 4'b1000, 8'h04, 4'b1000}, '{8'h04, 3'b001, 4'b0100, 8'h04, 4'b1010},
    '{8'h86, 3'b100, 4'b0010, 8'h86, 4'b0010}, '{8'h48, 3'b010, 4'b0010, 8'h48, 4'b0110},
    '{8'h48, 3'b100, 4'b1111, 8'h48, 4'b1101}, '{8'h4a, 3'b100, 4'b0001, 8'h4a, 4'b1110},
    '{8'h4a, 3'b010, 4'b1111, 8'h4a, 4'b0101}, '{8'h41, 3'b111, 4'b1111, 8'h41, 4'b1110},
    '{8'hc6, 3'b111, 4'b1111, 8'hc6, 4'b0110}, '{8'h8b, 3'b011, 4'b1111, 8'h8b, 4'b0001}};

  // ==========================================================
  // design under test
  clock_source_config i_clock_source_config (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_write(i_reg_write), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_custom_mode(i_custom_mode),
    .i_controller_mode(i_controller_mode), .i_dsp_load_high(i_dsp_load_high),
    .i_primary_bit_clock(i_primary_bit_clock), .i_secondary_bit_clock(i_secondary_bit_clock),
    .i_controller_ref_clock(i_controller_ref_clock), .i_internal_osc(i_internal_osc),
    .i_primary_frame_sync(i_primary_frame_sync), .i_secondary_frame_sync(i_secondary_frame_sync),
    .o_loop_enable(o_loop_enable), .o_fractional_allow(o_fractional_allow),
    .o_source_clock(o_source_clock), .o_source_invalid(o_source_invalid),
    .o_density_mod_clock_rate(o_density_mod_clock_rate), .o_ratio_auto(o_ratio_auto),
    .o_ref_frame_ratio(o_ref_frame_ratio), .o_ratio_locked(o_ratio_locked), .o_ratio_error(o_ratio_error));

  // ==========================================================
  // clock and hang guard
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  // cut the run short if a wait hangs
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      test_done();
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one write strobe, returns at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_write <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_reg_addr <= a;
    @(negedge i_clk);
    chk("read data", o_reg_rdata, exp);
  endtask
  // frame start on one port, then n toggles of that port's bit clock
  task automatic frm(input bit sec, input int n);
    @(posedge i_clk);
    if (sec) i_secondary_frame_sync <= 1'b1;
    else i_primary_frame_sync <= 1'b1;
    @(posedge i_clk);
    i_secondary_frame_sync <= 1'b0;
    i_primary_frame_sync <= 1'b0;
    repeat (2) @(posedge i_clk);
    for (int t = 0; t < n; t++) begin
      if (sec) i_secondary_bit_clock <= ~i_secondary_bit_clock;
      else i_primary_bit_clock <= ~i_primary_bit_clock;
      repeat (2) @(posedge i_clk);
    end
    @(negedge i_clk);
  endtask
  task automatic ratio_chk(input logic [13:0] r, input logic lk, input logic er);
    chk("ratio", o_ref_frame_ratio, r);
    chk("locked", o_ratio_locked, lk);
    chk("error", o_ratio_error, er);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(clock_source_pkg::clock_source_config_addr, 8'h40);
    rd(clock_source_pkg::ratio_high_addr, 8'h00);
    rd(clock_source_pkg::ratio_low_addr, 8'h00);
    chk("fractional after reset", o_fractional_allow, 1'b1);
    rd(8'h37, 8'h00);
    // table of source, loop and fraction settings
    for (int k = 0; k < 12; k++) begin
      @(posedge i_clk);
      {i_custom_mode, i_controller_mode, i_dsp_load_high} <= rows[k].mode;
      {i_primary_bit_clock, i_secondary_bit_clock, i_controller_ref_clock, i_internal_osc} <= rows[k].lvl;
      wr(clock_source_pkg::clock_source_config_addr, rows[k].wd);
      @(negedge i_clk);
      chk("source register", o_reg_rdata, rows[k].rd);
      chk("loop and source", flags, rows[k].exp);
    end
    wr(8'h37, 8'h11);
    rd(clock_source_pkg::clock_source_config_addr, 8'h8b);
    // every density clock rate code
    for (int r = 0; r < 4; r++) begin
      wr(clock_source_pkg::ratio_high_addr, {r[1:0], 6'h00});
      @(negedge i_clk);
      chk("density rate", o_density_mod_clock_rate, r[1:0]);
    end
    // auto ratio, primary port, rising edges
    @(posedge i_clk);
    {i_primary_bit_clock, i_secondary_bit_clock} <= 2'b00;
    wr(clock_source_pkg::clock_source_config_addr, 8'h40);
    wr(clock_source_pkg::ratio_high_addr, 8'h00);
    frm(1'b0, 6);
    frm(1'b0, 0);
    chk("auto flag", o_ratio_auto, 1'b1);
    ratio_chk(14'd3, 1'b1, 1'b0);
    // programmed ratio three, match then mismatch
    wr(clock_source_pkg::ratio_low_addr, 8'h03);
    frm(1'b0, 6);
    frm(1'b0, 7);
    chk("auto flag", o_ratio_auto, 1'b0);
    ratio_chk(14'd3, 1'b1, 1'b0);
    frm(1'b0, 0);
    ratio_chk(14'd3, 1'b0, 1'b1);
    // secondary port, falling edges, auto
    wr(clock_source_pkg::clock_source_config_addr, 8'h45);
    wr(clock_source_pkg::ratio_low_addr, 8'h00);
    frm(1'b1, 5);
    frm(1'b1, 0);
    ratio_chk(14'd2, 1'b1, 1'b0);
    // largest programmed ratio through both bytes
    wr(clock_source_pkg::ratio_high_addr, 8'hff);
    wr(clock_source_pkg::ratio_low_addr, 8'hff);
    rd(clock_source_pkg::ratio_high_addr, 8'hff);
    rd(clock_source_pkg::ratio_low_addr, 8'hff);
    frm(1'b1, 0);
    ratio_chk(14'h3fff, 1'b0, 1'b1);
    // second reset in mid-run
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(clock_source_pkg::clock_source_config_addr, 8'h40);
    rd(clock_source_pkg::ratio_high_addr, 8'h00);
    ratio_chk(14'h0000, 1'b0, 1'b0);
    test_done();
  end
endmodule // clock_source_config_tb_top
